// *** rtl/tlirq_defines.svh ***
/*
 * register addresses, source bit positions and reset values of the
 * top-level interrupt enable and pending control block.
 * assumes inclusion by bare name from any design file that needs them.
 */
`ifndef TLIRQ_DEFINES_SVH
`define TLIRQ_DEFINES_SVH

// register byte addresses
`define TLIRQ_ADDR_ENABLE_SET   32'hE000_E100
`define TLIRQ_ADDR_ENABLE_CLEAR 32'hE000_E180
`define TLIRQ_ADDR_PENDING_SET  32'hE000_E200
`define TLIRQ_ADDR_PENDING_CLR  32'hE000_E280

// source bit positions
`define TLIRQ_BIT_DEBUG      16
`define TLIRQ_BIT_EXT_FOUR   15
`define TLIRQ_BIT_EXT_THREE  14
`define TLIRQ_BIT_EXT_ONE    12
`define TLIRQ_BIT_RADIO_RX   10
`define TLIRQ_BIT_RADIO_TX   9
`define TLIRQ_BIT_RADIO_TMR  8
`define TLIRQ_BIT_CRYPTO     7
`define TLIRQ_BIT_SERIAL_ONE 5
`define TLIRQ_BIT_SLEEP      4
`define TLIRQ_BIT_BASEBAND   3
`define TLIRQ_BIT_MGMT       2

// implemented source mask and reset value
`define TLIRQ_SRC_MASK 32'h0001_D7BC
`define TLIRQ_RESET    32'h0000_0000

`endif

// *** rtl/tlirq_pkg.sv ***
/*
 * types shared by the top-level interrupt control block.
 * assumes tlirq_defines.svh is available on the include path.
 */
package tlirq_pkg;
    typedef logic [31:0] tlirq_word_t;

    // all state of the controller
    typedef struct packed {
        tlirq_word_t enable;
        tlirq_word_t pending;
        tlirq_word_t rdata;
    } tlirq_state_s;
endpackage

// *** rtl/tlirq_ctrl.sv ***
/*
 * top-level interrupt enable and pending control for twelve sources.
 * assumes a register master that follows a one-cycle strobe protocol
 * and peripheral sources that present one-cycle or level request pulses.
 */
`timescale 1ns/1ns
`include "tlirq_defines.svh"

module tlirq_ctrl #(
    // word width of the register port and of every per-source register
    parameter int unsigned WORD_BITS = 32,
    // number of live sources in the map
    parameter int unsigned NUM_SOURCES = 12
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register port
    input wire logic [31:0] reg_addr,
    input wire tlirq_pkg::tlirq_word_t reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output tlirq_pkg::tlirq_word_t reg_rdata,
    // peripheral request pulses, one per source bit
    input wire tlirq_pkg::tlirq_word_t src_request,
    // request lines to the core
    output tlirq_pkg::tlirq_word_t core_irq
);
    import tlirq_pkg::*;

    tlirq_state_s state_q;
    tlirq_state_s state_d;
    tlirq_word_t src_mask;
    logic hit_en_set;
    logic hit_en_clr;
    logic hit_pd_set;
    logic hit_pd_clr;
    logic hit_any;

    // elaboration guard: the source map is fixed to one 32-bit word
    if (WORD_BITS != $bits(tlirq_word_t)) begin
        $error("WORD_BITS must equal the per-source register width");
    end
    // the live map must hold exactly the expected number of sources
    if (NUM_SOURCES != $countones(`TLIRQ_SRC_MASK)) begin
        $error("NUM_SOURCES does not match the live source map");
    end

    // write-one-to-set: only live one-bits join the old state
    function automatic tlirq_word_t set_ones(
        input tlirq_word_t old,
        input tlirq_word_t ones,
        input tlirq_word_t live
    );
        return old | (ones & live);
    endfunction

    // write-one-to-clear: only live one-bits leave the old state
    function automatic tlirq_word_t clear_ones(
        input tlirq_word_t old,
        input tlirq_word_t ones,
        input tlirq_word_t live
    );
        return old & ~(ones & live);
    endfunction

    // read view: reserved positions always read zero
    function automatic tlirq_word_t live_view(
        input tlirq_word_t word,
        input tlirq_word_t live
    );
        return word & live;
    endfunction

    // source map, assembled from named positions
    always_comb begin
        src_mask = '0;
        src_mask[`TLIRQ_BIT_RADIO_RX] = 1'b1;
        src_mask[`TLIRQ_BIT_RADIO_TX] = 1'b1;
        src_mask[`TLIRQ_BIT_RADIO_TMR] = 1'b1;
        src_mask[`TLIRQ_BIT_EXT_FOUR] = 1'b1;
        src_mask[`TLIRQ_BIT_EXT_THREE] = 1'b1;
        src_mask[`TLIRQ_BIT_EXT_ONE] = 1'b1;
        src_mask[`TLIRQ_BIT_DEBUG] = 1'b1;
        src_mask[`TLIRQ_BIT_CRYPTO] = 1'b1;
        src_mask[`TLIRQ_BIT_SERIAL_ONE] = 1'b1;
        src_mask[`TLIRQ_BIT_SLEEP] = 1'b1;
        src_mask[`TLIRQ_BIT_BASEBAND] = 1'b1;
        src_mask[`TLIRQ_BIT_MGMT] = 1'b1;
    end

    // address decode; unmapped addresses read zero and ignore writes
    assign hit_en_set = (reg_addr == `TLIRQ_ADDR_ENABLE_SET);
    assign hit_en_clr = (reg_addr == `TLIRQ_ADDR_ENABLE_CLEAR);
    assign hit_pd_set = (reg_addr == `TLIRQ_ADDR_PENDING_SET);
    assign hit_pd_clr = (reg_addr == `TLIRQ_ADDR_PENDING_CLR);
    assign hit_any = hit_en_set | hit_en_clr | hit_pd_set | hit_pd_clr;

    // next state: only one-bits act, reserved bits masked away
    always_comb begin
        state_d = state_q;
        // read data stand for one cycle only, zero otherwise
        state_d.rdata = '0;
        // enable-set and enable-clear sit at separate addresses, so one acts at most
        if (reg_write && hit_en_set) begin
            state_d.enable = set_ones(state_q.enable, reg_wdata, src_mask);
        end
        if (reg_write && hit_en_clr) begin
            state_d.enable = clear_ones(state_q.enable, reg_wdata, src_mask);
        end
        // software clear first so a same-cycle source request still wins
        if (reg_write && hit_pd_clr) begin
            state_d.pending = clear_ones(state_q.pending, reg_wdata, src_mask);
        end
        if (reg_write && hit_pd_set) begin
            state_d.pending = set_ones(state_d.pending, reg_wdata, src_mask);
        end
        // a disabled source still pends; the enable only gates the core line
        state_d.pending = set_ones(state_d.pending, src_request, src_mask);
        // set registers and clear registers alike show current state
        // reads see the state before any write taken at the same edge
        if (reg_read) begin
            if (hit_en_set || hit_en_clr) begin
                state_d.rdata = live_view(state_q.enable, src_mask);
            end else if (hit_pd_set || hit_pd_clr) begin
                state_d.rdata = live_view(state_q.pending, src_mask);
            end
        end
    end

    // single state register
    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= '{enable: `TLIRQ_RESET, pending: `TLIRQ_RESET, rdata: '0};
        end else begin
            state_q <= state_d;
        end
    end

    assign reg_rdata = state_q.rdata;
    // combinational so a pend in one cycle reaches the core the next
    assign core_irq = state_q.enable & state_q.pending;

    // assertions
    property p_en_clear;
        @(posedge clock) disable iff (reset)
        reg_write && hit_en_clr && reg_wdata[`TLIRQ_BIT_DEBUG] |=> !core_irq[`TLIRQ_BIT_DEBUG];
    endproperty
    a_en_clear: assert property (p_en_clear) else $error("enable clear ignored");

    property p_zero_keeps;
        @(posedge clock) disable iff (reset)
        reg_write && (hit_en_clr || hit_pd_clr) && reg_wdata == '0
        |=> state_q.enable == $past(state_q.enable);
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed state");

    property p_pend_set;
        @(posedge clock) disable iff (reset)
        reg_write && hit_pd_set && reg_wdata[`TLIRQ_BIT_RADIO_RX]
        |=> state_q.pending[`TLIRQ_BIT_RADIO_RX];
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("pending set lost");

    property p_pend_clr;
        @(posedge clock) disable iff (reset)
        reg_write && hit_pd_clr && reg_wdata[`TLIRQ_BIT_MGMT] && !src_request[`TLIRQ_BIT_MGMT]
        |=> !state_q.pending[`TLIRQ_BIT_MGMT];
    endproperty
    a_pend_clr: assert property (p_pend_clr) else $error("pending clear ignored");

    property p_map;
        @(posedge clock) disable iff (reset)
        reg_write && hit_en_set && reg_wdata == 32'hFFFF_FFFF
        |=> (state_q.enable & ~src_mask) == '0 ##0 src_mask == `TLIRQ_SRC_MASK;
    endproperty
    a_map: assert property (p_map) else $error("map wrong");

    property p_reset;
        @(posedge clock) reset |=> state_q.enable == '0 && state_q.pending == '0 && reg_rdata == '0;
    endproperty
    a_reset: assert property (p_reset) else $error("reset value not zero");

    property p_en_set;
        @(posedge clock) disable iff (reset)
        reg_write && hit_en_set && reg_wdata[`TLIRQ_BIT_SLEEP]
        |=> state_q.enable[`TLIRQ_BIT_SLEEP];
    endproperty
    a_en_set: assert property (p_en_set) else $error("enable set lost");

    property p_read_back;
        @(posedge clock) disable iff (reset)
        reg_read && hit_pd_clr |=> reg_rdata == ($past(state_q.pending) & src_mask);
    endproperty
    a_read_back: assert property (p_read_back) else $error("read data wrong");

    // every live one written to enable-clear leaves its source disabled
    property p_en_clr_all;
        @(posedge clock) disable iff (reset)
        reg_write && hit_en_clr
        |=> (state_q.enable & $past(reg_wdata) & src_mask) == '0;
    endproperty
    a_en_clr_all: assert property (p_en_clr_all) else $error("enable clear missed");

    // zero bits of an enable-clear write keep their enable
    property p_en_clr_keep;
        @(posedge clock) disable iff (reset)
        reg_write && hit_en_clr
        |=> ((state_q.enable ^ $past(state_q.enable)) & ~$past(reg_wdata)) == '0;
    endproperty
    a_en_clr_keep: assert property (p_en_clr_keep) else $error("zero bit cleared");

    // zero bits of an enable-set write keep their enable
    property p_en_set_keep;
        @(posedge clock) disable iff (reset)
        reg_write && hit_en_set
        |=> ((state_q.enable ^ $past(state_q.enable)) & ~$past(reg_wdata)) == '0;
    endproperty
    a_en_set_keep: assert property (p_en_set_keep) else $error("zero bit enabled");

    // zero bits of a pending-set write move only with a source event
    property p_pd_set_keep;
        @(posedge clock) disable iff (reset)
        reg_write && hit_pd_set
        |=> ((state_q.pending ^ $past(state_q.pending)) & ~$past(reg_wdata)
            & ~$past(src_request)) == '0;
    endproperty
    a_pd_set_keep: assert property (p_pd_set_keep) else $error("zero bit pended");

    // zero bits of a pending-clear write move only with a source event
    property p_pd_clr_keep;
        @(posedge clock) disable iff (reset)
        reg_write && hit_pd_clr
        |=> ((state_q.pending ^ $past(state_q.pending)) & ~$past(reg_wdata)
            & ~$past(src_request)) == '0;
    endproperty
    a_pd_clr_keep: assert property (p_pd_clr_keep) else $error("zero bit unpended");

    // every live one written to enable-set enables its source
    property p_en_set_all;
        @(posedge clock) disable iff (reset)
        reg_write && hit_en_set
        |=> (~state_q.enable & $past(reg_wdata) & src_mask) == '0;
    endproperty
    a_en_set_all: assert property (p_en_set_all) else $error("enable set missed");

    // every live one written to pending-set pends its source
    property p_pd_set_all;
        @(posedge clock) disable iff (reset)
        reg_write && hit_pd_set
        |=> (~state_q.pending & $past(reg_wdata) & src_mask) == '0;
    endproperty
    a_pd_set_all: assert property (p_pd_set_all) else $error("pending set missed");

    // every live one written to pending-clear withdraws it, unless a source pends again
    property p_pd_clr_all;
        @(posedge clock) disable iff (reset)
        reg_write && hit_pd_clr
        |=> (state_q.pending & $past(reg_wdata) & src_mask & ~$past(src_request)) == '0;
    endproperty
    a_pd_clr_all: assert property (p_pd_clr_all) else $error("pending clear missed");

    // a hardware event on a live source pends it one cycle later
    property p_src_pends;
        @(posedge clock) disable iff (reset)
        (src_request & src_mask) != '0
        |=> (~state_q.pending & $past(src_request) & src_mask) == '0;
    endproperty
    a_src_pends: assert property (p_src_pends) else $error("source event lost");

    // a source event beats a pending-clear write in the same cycle
    property p_set_wins;
        @(posedge clock) disable iff (reset)
        reg_write && hit_pd_clr && src_request[`TLIRQ_BIT_MGMT]
        |=> state_q.pending[`TLIRQ_BIT_MGMT];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat source");

    // reserved positions never hold enable or pending state
    property p_rsvd_state;
        @(posedge clock) disable iff (reset)
        ((state_q.enable | state_q.pending) & ~src_mask) == '0;
    endproperty
    a_rsvd_state: assert property (p_rsvd_state) else $error("reserved bit set");

    // reserved positions always read zero
    property p_rsvd_read;
        @(posedge clock) disable iff (reset)
        (reg_rdata & ~src_mask) == '0;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bit read");

    // a write to an unmapped address leaves the enables alone
    property p_unmapped_wr;
        @(posedge clock) disable iff (reset)
        reg_write && !hit_any
        |=> state_q.enable == $past(state_q.enable);
    endproperty
    a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write acted");

    // a read of an unmapped address returns zero
    property p_unmapped_rd;
        @(posedge clock) disable iff (reset)
        reg_read && !hit_any
        |=> reg_rdata == '0;
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read data");

    // read data stand only in the cycle after a read strobe
    property p_rdata_idle;
        @(posedge clock) disable iff (reset)
        !reg_read
        |=> reg_rdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data lingered");

    // both enable registers read back the current enables
    property p_read_enable;
        @(posedge clock) disable iff (reset)
        reg_read && (hit_en_set || hit_en_clr)
        |=> reg_rdata == ($past(state_q.enable) & src_mask);
    endproperty
    a_read_enable: assert property (p_read_enable) else $error("enable read wrong");

    // pending an enabled source raises its core line at once
    property p_irq_pend;
        @(posedge clock) disable iff (reset)
        reg_write && hit_pd_set
        |=> (state_q.enable & $past(reg_wdata) & src_mask & ~core_irq) == '0;
    endproperty
    a_irq_pend: assert property (p_irq_pend) else $error("pend did not raise");

    // a disabled source never reaches the core
    property p_irq_gated;
        @(posedge clock) disable iff (reset)
        (core_irq & ~state_q.enable) == '0;
    endproperty
    a_irq_gated: assert property (p_irq_gated) else $error("disabled line raised");

    // a core line needs its source pending
    property p_irq_needs_pend;
        @(posedge clock) disable iff (reset)
        (core_irq & ~state_q.pending) == '0;
    endproperty
    a_irq_needs_pend: assert property (p_irq_needs_pend) else $error("line not pending");
endmodule

// *** dv/tlirq_src_model.sv ***
/* peripheral source model: registers a request word onto the request lines a cycle later.
   assumes the bench sets raise by non-blocking assignment at a rising edge. */
`timescale 1ns/1ns
module tlirq_src_model (
    // clock
    input wire logic clock,
    // events to raise, and the request lines they become
    input wire logic [31:0] raise,
    output logic [31:0] src_request
);
    // request lines follow raise one cycle late; pending must hold an event, the source does not
    always_ff @(posedge clock) src_request <= raise;
endmodule

// *** dv/tb_top_level_irq_enable_pend_ctrl.sv ***
/* bench for the interrupt enable and pending block: register tasks, scenarios.
   assumes the defines header on the include path and a source model beside it. */
`timescale 1ns/1ns
`include "tlirq_defines.svh"
module tb_top_level_irq_enable_pend_ctrl;
    import tlirq_pkg::*;
    localparam logic [31:0] ES = `TLIRQ_ADDR_ENABLE_SET;
    localparam logic [31:0] EC = `TLIRQ_ADDR_ENABLE_CLEAR;
    localparam logic [31:0] PS = `TLIRQ_ADDR_PENDING_SET;
    localparam logic [31:0] PC = `TLIRQ_ADDR_PENDING_CLR;
    localparam logic [31:0] M = `TLIRQ_SRC_MASK;
    logic clock = 0, reset = 1, reg_write = 0, reg_read = 0;
    logic [31:0] reg_addr = 0, raise = 0, r;
    tlirq_word_t reg_wdata = 0, reg_rdata, src_request, core_irq;
    int n_errors = 0, checked = 0;
    int bits[12] = '{16, 15, 14, 12, 10, 9, 8, 7, 5, 4, 3, 2};
    logic [31:0] addrs[4] = '{ES, EC, PS, PC};
    always #4 clock = ~clock;
    tlirq_ctrl uut (.clock(clock), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .src_request(src_request), .core_irq(core_irq));
    tlirq_src_model src (.clock(clock), .raise(raise), .src_request(src_request));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle write; new state is visible just after the taking edge
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_write <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 0;
        #1;
    endtask
    // read data stands only in the cycle after the strobe, so sample there
    task automatic rd(input logic [31:0] a);
        @(posedge clock);
        reg_read <= 1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 0;
        #1 r = reg_rdata;
    endtask
    task automatic t_reset;
        foreach (addrs[i]) begin
            rd(addrs[i]);
            chk(r, 32'h0000_0000);
        end
        chk(core_irq, 32'h0000_0000);
    endtask
    // each source alone, pended then withdrawn, must reach its own line
    task automatic t_map;
        wr(ES, 32'hFFFF_FFFF);
        rd(EC);
        chk(r, M);
        foreach (bits[i]) begin
            wr(PS, 32'h0000_0001 << bits[i]);
            chk(core_irq, 32'h0000_0001 << bits[i]);
            wr(PC, 32'h0000_0001 << bits[i]);
            chk(core_irq, 32'h0000_0000);
        end
    endtask
    // partial clears, plus an unmapped address that must change nothing
    task automatic t_clear;
        wr(PS, 32'hFFFF_FFFF);
        rd(PC);
        chk(r, M);
        wr(EC, 32'h0000_0400);
        rd(ES);
        chk(r, M ^ 32'h0000_0400);
        chk(core_irq, M ^ 32'h0000_0400);
        wr(PC, 32'h0000_8004);
        wr(32'hE000_E300, 32'hFFFF_FFFF);
        rd(32'hE000_E300);
        chk(r, 32'h0000_0000);
        rd(PS);
        chk(r, M ^ 32'h0000_8004);
    endtask
    // hardware events: disabled source pends silently, reserved bit ignored
    task automatic t_source;
        wr(PC, 32'hFFFF_FFFF);
        @(posedge clock);
        raise <= 32'h0000_8402;
        @(posedge clock);
        raise <= 32'h0000_0000;
        repeat (2) @(posedge clock);
        #1 chk(core_irq, 32'h0000_8000);
        rd(PS);
        chk(r, 32'h0000_8400);
    endtask
    // a disabled source keeps its pending state but drops its core line
    task automatic t_disable;
        wr(PS, 32'h0001_0000);
        chk(core_irq, 32'h0001_8000);
        wr(EC, 32'h0001_0000);
        chk(core_irq, 32'h0000_8000);
        rd(PS);
        chk(r, 32'h0001_8400);
    endtask
    // all-zero words written to every register change nothing
    task automatic t_zero;
        foreach (addrs[i]) begin
            wr(addrs[i], 32'h0000_0000);
        end
        rd(ES);
        chk(r, M ^ 32'h0001_0400);
        rd(PC);
        chk(r, 32'h0001_8400);
        chk(core_irq, 32'h0000_8000);
    endtask
    // a source event taken with a pending-clear write must survive it
    task automatic t_race;
        @(posedge clock);
        raise <= 32'h0000_0004;
        @(posedge clock);
        raise <= 32'h0000_0000;
        reg_write <= 1;
        reg_addr <= PC;
        reg_wdata <= 32'h0001_8404;
        @(posedge clock);
        reg_write <= 0;
        #1 chk(core_irq, 32'h0000_0004);
        rd(PS);
        chk(r, 32'h0000_0004);
    endtask
    // a second reset in mid-run returns every register to zero
    task automatic t_rereset;
        @(posedge clock);
        reset <= 1;
        repeat (2) @(posedge clock);
        reset <= 0;
        t_reset;
    endtask
    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clock);
        reset <= 0;
        t_reset;
        t_map;
        t_clear;
        t_source;
        t_disable;
        t_zero;
        t_race;
        t_rereset;
        give_verdict;
    end
endmodule
